// [rxd_pkg.sv]
// shared constants and carriers for the receive descriptor dma
`default_nettype none
package rxd_pkg;
  // descriptor word offsets from the descriptor start, OFS_FLEN from the fragment entry
  localparam logic [31:0] OFS_NEXT     = 32'h0000_0000;
  localparam logic [31:0] OFS_STATUS   = 32'h0000_0004;
  localparam logic [31:0] OFS_FRAG     = 32'h0000_0008;
  localparam logic [31:0] OFS_FLEN     = 32'h0000_0004;
  localparam logic [31:0] FRAG_STRIDE  = 32'h0000_0008;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  // status word field positions
  localparam int LEN_W        = 13;
  localparam int BIT_ERROR    = 14;
  localparam int BIT_COMPLETE = 15;
  localparam int BIT_OVERRUN  = 16;
  localparam int BIT_SHORT    = 17;
  localparam int BIT_ALIGN    = 18;
  localparam int BIT_CHECKSUM = 19;
  localparam int BIT_OVERSIZE = 20;
  localparam int BIT_TRAIL    = 23;
  localparam int BIT_OVERFLOW = 24;
  localparam int BIT_SINGLE   = 28;
  localparam int BIT_FINAL    = 31;
  // single buffer size and short frame limit, in bytes
  localparam logic [LEN_W-1:0] SINGLE_BUF_LEN = 13'h05F8;
  localparam logic [15:0]      SHORT_LIMIT    = 16'h003C;
  // buffer depth in the data path
  localparam int BUF_DEPTH = 2;

  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_NEXT  = 10'h002,
    ST_STAT  = 10'h004,
    ST_FADDR = 10'h008,
    ST_FLEN  = 10'h010,
    ST_WAIT  = 10'h020,
    ST_XFER  = 10'h040,
    ST_DRAIN = 10'h080,
    ST_WSTAT = 10'h100,
    ST_HALT  = 10'h200
  } rxd_state_t;

  // one memory request of the bus master
  typedef struct packed {
    logic        we;
    logic [3:0]  be;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rxd_mem_cmd_t;

  // one byte of frame data from the receive fifo
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } rxd_beat_t;

  // per-frame information known before the frame's data moves
  typedef struct packed {
    logic [15:0] len;
    logic        checksum_bad;
    logic        trailing_bits;
    logic        fifo_overrun;
  } rxd_frame_info_t;
endpackage : rxd_pkg
`default_nettype wire

// [rxd_buf.sv]
// two-entry valid/ready buffer for the frame byte stream
`default_nettype none
module rxd_buf #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             in_ready_o,
  output var  logic             out_valid_o,
  output var  logic [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // refuse depths the pointer logic cannot serve
  if (DEPTH < 2 || WIDTH < 1) begin : g_check
    $error("rxd_buf: DEPTH must be at least 2 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             next_ready;
  logic             push;
  logic             pop;

  // pointer, count and ready update
  always_comb begin
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
    end
    if (push && !pop) begin
      next_count = count + CW'(1);
    end else if (pop && !push) begin
      next_count = count - CW'(1);
    end
    next_ready = next_count < CW'(DEPTH);
  end

  // registers of the buffer
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_ready_o <= 1'b0;
    end else begin
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      count      <= next_count;
      in_ready_o <= next_ready;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  assign out_valid_o = count != '0;
  assign out_data_o  = mem[rd_ptr];
endmodule : rxd_buf
`default_nettype wire

// [rxd_dma.sv]
// receive descriptor chain walker with frame write-back
//
// Behaviour
// - status copied to descriptor offset four
// - length cleared per fetch, grows by one per byte written
// - final length equals frame length unless overflow
// - buffers full: fill, drop rest, flag overflow
// - set complete, then fetch next unless halted
// - error flag when any bit 16-20 set
// - flag fifo overrun, bytes may be missing
// - flag short frames, pass only on early receive
// - alignment error: bad checksum plus trailing bits
// - flag checksum mismatch
// - flag length at or above size limit
// - trailing bits flag is informational only
// - single buffer mode: one 1528-byte buffer
// - sample single mode with complete before transfer
// - fragment address from even words, any alignment
// - fragment length from low 13 bits
// - final fragment flag ends buffer space
// - written status mirrors register except bit 28
`default_nettype none
module rxd_dma (
  input  wire logic                    clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    start_i,
  input  wire logic [31:0]             list_ptr_i,
  input  wire logic                    halt_i,
  input  wire logic                    early_receive_enable_i,
  input  wire logic [12:0]             early_receive_threshold_i,
  input  wire logic [15:0]             frame_size_limit_i,
  input  wire logic                    frame_avail_i,
  input  wire rxd_pkg::rxd_frame_info_t frame_info_i,
  output var  logic                    frame_take_o,
  input  wire logic                    in_valid_i,
  input  wire rxd_pkg::rxd_beat_t      in_beat_i,
  output var  logic                    in_ready_o,
  output var  logic                    mem_req_o,
  output var  rxd_pkg::rxd_mem_cmd_t   mem_cmd_o,
  input  wire logic                    mem_ack_i,
  input  wire logic [31:0]             mem_rdata_i,
  output var  logic [31:0]             status_o,
  output var  logic [31:0]             current_descriptor_pointer_o,
  output var  logic                    busy_o,
  output var  logic                    frame_done_o
);
  import rxd_pkg::*;

  rxd_state_t        state;
  rxd_state_t        next_state;
  logic [31:0]       next_descriptor_pointer;
  logic [31:0]       next_next_ptr;
  logic [31:0]       next_cur_ptr;
  logic [31:0]       frag_ptr;
  logic [31:0]       next_frag_ptr;
  logic [31:0]       buf_addr;
  logic [31:0]       next_buf_addr;
  logic [LEN_W-1:0]  buf_left;
  logic [LEN_W-1:0]  next_buf_left;
  logic              final_fragment;
  logic              next_final_fragment;
  logic              single_buffer_mode;
  logic              next_single_buffer_mode;
  logic              frame_started;
  logic              next_frame_started;
  logic              drop_frame;
  logic              next_drop_frame;
  logic [31:0]       next_status;
  logic              next_req;
  rxd_mem_cmd_t      next_cmd;
  logic              next_take;
  logic              next_done;
  logic              advance;
  logic              acked;
  logic              buf_valid;
  logic              buf_pop;
  rxd_beat_t         buf_beat;

  // read request for one descriptor word
  function automatic rxd_mem_cmd_t rd_cmd(input logic [31:0] addr);
    rxd_mem_cmd_t c;
    c.we    = 1'b0;
    c.be    = 4'hF;
    c.addr  = addr;
    c.wdata = 32'h0000_0000;
    return c;
  endfunction : rd_cmd

  // write request of a full word at a word address
  function automatic rxd_mem_cmd_t wr_cmd(input logic [31:0] addr, input logic [31:0] data);
    rxd_mem_cmd_t c;
    c.we    = 1'b1;
    c.be    = 4'hF;
    c.addr  = addr;
    c.wdata = data;
    return c;
  endfunction : wr_cmd

  // byte write at any byte address
  function automatic rxd_mem_cmd_t byte_cmd(input logic [31:0] addr, input logic [7:0] data);
    rxd_mem_cmd_t c;
    c.we    = 1'b1;
    c.be    = 4'h1 << addr[1:0];
    c.addr  = {addr[31:2], 2'h0};
    c.wdata = {4{data}};
    return c;
  endfunction : byte_cmd

  // frame data passes the two-entry buffer so a stall loses nothing
  rxd_buf #(
    .WIDTH ($bits(rxd_beat_t)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (in_valid_i),
    .in_data_i   (in_beat_i),
    .in_ready_o  (in_ready_o),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_beat),
    .out_ready_i (buf_pop)
  );

  // descriptor walk and transfer sequencing
  always_comb begin
    next_state              = state;
    next_next_ptr           = next_descriptor_pointer;
    next_cur_ptr            = current_descriptor_pointer_o;
    next_frag_ptr           = frag_ptr;
    next_buf_addr           = buf_addr;
    next_buf_left           = buf_left;
    next_final_fragment     = final_fragment;
    next_single_buffer_mode = single_buffer_mode;
    next_frame_started      = frame_started;
    next_drop_frame         = drop_frame;
    next_status             = status_o;
    acked                   = mem_req_o && mem_ack_i;
    next_req                = mem_req_o && !mem_ack_i;
    next_cmd                = mem_cmd_o;
    next_take               = 1'b0;
    next_done               = 1'b0;
    advance                 = 1'b0;
    buf_pop                 = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_i) begin
          next_cur_ptr = list_ptr_i;
          next_status  = STATUS_RESET;
          next_req     = 1'b1;
          next_cmd     = rd_cmd(list_ptr_i + OFS_NEXT);
          next_state   = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (acked) begin
          next_next_ptr = mem_rdata_i;
          next_req      = 1'b1;
          next_cmd      = rd_cmd(current_descriptor_pointer_o + OFS_STATUS);
          next_state    = ST_STAT;
        end
      end
      ST_STAT: begin
        if (acked) begin
          next_single_buffer_mode = mem_rdata_i[BIT_SINGLE];
          if (mem_rdata_i[BIT_COMPLETE]) begin
            // descriptor not yet released by the host, look again
            next_req = 1'b1;
            next_cmd = rd_cmd(current_descriptor_pointer_o + OFS_STATUS);
          end else if (mem_rdata_i[BIT_SINGLE]) begin
            next_buf_addr       = current_descriptor_pointer_o + OFS_FRAG;
            next_buf_left       = SINGLE_BUF_LEN;
            next_final_fragment = 1'b1;
            next_state          = ST_WAIT;
          end else begin
            next_frag_ptr = current_descriptor_pointer_o + OFS_FRAG;
            next_req      = 1'b1;
            next_cmd      = rd_cmd(current_descriptor_pointer_o + OFS_FRAG);
            next_state    = ST_FADDR;
          end
        end
      end
      ST_FADDR: begin
        if (acked) begin
          next_buf_addr = mem_rdata_i;
          next_req      = 1'b1;
          next_cmd      = rd_cmd(frag_ptr + OFS_FLEN);
          next_state    = ST_FLEN;
        end
      end
      ST_FLEN: begin
        if (acked) begin
          next_buf_left       = mem_rdata_i[LEN_W-1:0];
          next_final_fragment = mem_rdata_i[BIT_FINAL];
          next_frag_ptr       = frag_ptr + FRAG_STRIDE;
          next_state          = frame_started ? ST_XFER : ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (frame_avail_i) begin
          next_take = 1'b1;
          next_status[BIT_OVERRUN]  = frame_info_i.fifo_overrun;
          next_status[BIT_SHORT]    = frame_info_i.len < SHORT_LIMIT;
          next_status[BIT_ALIGN]    = frame_info_i.checksum_bad
                                      && frame_info_i.trailing_bits;
          next_status[BIT_CHECKSUM] = frame_info_i.checksum_bad;
          next_status[BIT_OVERSIZE] = frame_info_i.len >= frame_size_limit_i;
          next_status[BIT_TRAIL]    = frame_info_i.trailing_bits;
          // short frames move only under early receive below their size
          if (frame_info_i.len < SHORT_LIMIT
              && !(early_receive_enable_i
                   && {3'h0, early_receive_threshold_i} < frame_info_i.len)) begin
            next_drop_frame = 1'b1;
            next_state      = ST_DRAIN;
          end else begin
            next_frame_started = 1'b1;
            next_state         = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        if (!mem_req_o && buf_valid) begin
          if (buf_left != '0) begin
            next_req = 1'b1;
            next_cmd = byte_cmd(buf_addr, buf_beat.data);
          end else if (final_fragment) begin
            next_status[BIT_OVERFLOW] = 1'b1;
            next_state                = ST_DRAIN;
          end else begin
            next_req   = 1'b1;
            next_cmd   = rd_cmd(frag_ptr);
            next_state = ST_FADDR;
          end
        end else if (acked) begin
          buf_pop       = 1'b1;
          next_buf_addr = buf_addr + 32'h0000_0001;
          next_buf_left = buf_left - LEN_W'(1);
          next_status[LEN_W-1:0] = status_o[LEN_W-1:0] + LEN_W'(1);
          if (buf_beat.last) begin
            next_state = ST_WSTAT;
          end
        end
      end
      ST_DRAIN: begin
        buf_pop = buf_valid;
        if (buf_valid && buf_beat.last) begin
          if (drop_frame) begin
            next_drop_frame = 1'b0;
            next_status     = STATUS_RESET;
            next_state      = ST_WAIT;
          end else begin
            next_state = ST_WSTAT;
          end
        end
      end
      ST_WSTAT: begin
        if (acked) begin
          next_done          = 1'b1;
          next_frame_started = 1'b0;
          if (halt_i) begin
            next_state = ST_HALT;
          end else begin
            advance = 1'b1;
          end
        end
      end
      ST_HALT: begin
        advance = !halt_i;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // completion and error summary, then the write-back request
    if (next_state == ST_WSTAT && state != ST_WSTAT) begin
      next_status[BIT_COMPLETE] = 1'b1;
      next_status[BIT_ERROR]    = |next_status[BIT_OVERSIZE:BIT_OVERRUN];
      next_req                  = 1'b1;
      next_cmd = wr_cmd(current_descriptor_pointer_o + OFS_STATUS,
                        {next_status[31:BIT_SINGLE+1], single_buffer_mode,
                         next_status[BIT_SINGLE-1:0]});
    end
    // move along the chain or stop at its end
    if (advance) begin
      if (next_descriptor_pointer == 32'h0000_0000) begin
        next_state = ST_IDLE;
      end else begin
        next_cur_ptr = next_descriptor_pointer;
        next_status  = STATUS_RESET;
        next_req     = 1'b1;
        next_cmd     = rd_cmd(next_descriptor_pointer + OFS_NEXT);
        next_state   = ST_NEXT;
      end
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state                        <= ST_IDLE;
      next_descriptor_pointer      <= 32'h0000_0000;
      current_descriptor_pointer_o <= 32'h0000_0000;
      frag_ptr                     <= 32'h0000_0000;
      buf_addr                     <= 32'h0000_0000;
      buf_left                     <= '0;
      final_fragment               <= 1'b0;
      single_buffer_mode           <= 1'b0;
      frame_started                <= 1'b0;
      drop_frame                   <= 1'b0;
      status_o                     <= STATUS_RESET;
      mem_req_o                    <= 1'b0;
      mem_cmd_o                    <= '0;
      frame_take_o                 <= 1'b0;
      frame_done_o                 <= 1'b0;
      busy_o                       <= 1'b0;
    end else begin
      state                        <= next_state;
      next_descriptor_pointer      <= next_next_ptr;
      current_descriptor_pointer_o <= next_cur_ptr;
      frag_ptr                     <= next_frag_ptr;
      buf_addr                     <= next_buf_addr;
      buf_left                     <= next_buf_left;
      final_fragment               <= next_final_fragment;
      single_buffer_mode           <= next_single_buffer_mode;
      frame_started                <= next_frame_started;
      drop_frame                   <= next_drop_frame;
      status_o                     <= next_status;
      mem_req_o                    <= next_req;
      mem_cmd_o                    <= next_cmd;
      frame_take_o                 <= next_take;
      frame_done_o                 <= next_done;
      busy_o                       <= next_state != ST_IDLE;
    end
  end
endmodule : rxd_dma
`default_nettype wire

// [rxd_dma_asserts.sv]
// concurrent checks on the receive descriptor dma ports
`default_nettype none
module rxd_dma_asserts
  import rxd_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  resetn_i,
  input wire logic                  start_i,
  input wire logic [31:0]           list_ptr_i,
  input wire logic                  frame_avail_i,
  input wire logic                  frame_take_o,
  input wire logic                  mem_req_o,
  input wire rxd_pkg::rxd_mem_cmd_t mem_cmd_o,
  input wire logic                  mem_ack_i,
  input wire logic [31:0]           status_o,
  input wire logic                  busy_o,
  input wire logic                  frame_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // request waiting for its acknowledge
  sequence s_stall;
    mem_req_o && !mem_ack_i;
  endsequence
  // status word freshly completed
  sequence s_fin;
    $rose(status_o[BIT_COMPLETE]);
  endsequence
  property p_hold;
    s_stall |=> mem_req_o && $stable(mem_cmd_o);
  endproperty
  property p_fetch;
    !busy_o && start_i |=> mem_req_o && !mem_cmd_o.we && mem_cmd_o.addr == $past(list_ptr_i);
  endproperty
  property p_done;
    frame_done_o |-> $past(mem_req_o && mem_ack_i && mem_cmd_o.we && mem_cmd_o.addr[2:0] == 3'h4);
  endproperty
  property p_err;
    s_fin |-> status_o[BIT_ERROR] == (|status_o[20:16]);
  endproperty
  property p_align;
    s_fin |-> status_o[BIT_ALIGN] == (status_o[BIT_CHECKSUM] && status_o[BIT_TRAIL]);
  endproperty
  property p_trail;
    s_fin ##0 (status_o[BIT_TRAIL] && !(|status_o[20:16])) |-> !status_o[BIT_ERROR];
  endproperty
  property p_len;
    busy_o && $past(busy_o) |-> status_o[12:0] == $past(status_o[12:0])
      || status_o[12:0] == $past(status_o[12:0]) + 13'h0001 || status_o[12:0] == 13'h0000;
  endproperty
  property p_idle;
    !busy_o |-> !mem_req_o;
  endproperty
  property p_be;
    mem_req_o && mem_cmd_o.we |-> $onehot(mem_cmd_o.be) || mem_cmd_o.be == 4'hF;
  endproperty
  property p_take;
    frame_take_o |-> $past(frame_avail_i) ##1 !frame_take_o;
  endproperty
  a_hold: assert property (p_hold) else $error("request dropped before ack");
  a_fetch: assert property (p_fetch) else $error("no fetch at list pointer");
  a_done: assert property (p_done) else $error("done without status write");
  a_err: assert property (p_err) else $error("error flag wrong");
  a_align: assert property (p_align) else $error("alignment flag wrong");
  a_trail: assert property (p_trail) else $error("trailing bits marked error");
  a_len: assert property (p_len) else $error("length step too big");
  a_idle: assert property (p_idle) else $error("request while idle");
  a_be: assert property (p_be) else $error("bad byte enables");
  a_take: assert property (p_take) else $error("take without frame info");
endmodule : rxd_dma_asserts
bind rxd_dma rxd_dma_asserts chk_u (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i),
  .list_ptr_i(list_ptr_i), .frame_avail_i(frame_avail_i), .frame_take_o(frame_take_o),
  .mem_req_o(mem_req_o), .mem_cmd_o(mem_cmd_o), .mem_ack_i(mem_ack_i),
  .status_o(status_o), .busy_o(busy_o), .frame_done_o(frame_done_o));
`default_nettype wire

// [rxd_mem_model.sv]
// host memory answering the dma's bus requests
`default_nettype none
module rxd_mem_model
  import rxd_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  slow_i,
  input  wire logic                  mem_req_i,
  input  wire rxd_pkg::rxd_mem_cmd_t mem_cmd_i,
  output var  logic                  mem_ack_o,
  output var  logic [31:0]           mem_rdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [logic [29:0]];
  logic [31:0] word;
  logic [2:0]  wait_cnt;
  // word store, unwritten words read as zero
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a[31:2]) ? mem[a[31:2]] : 32'h0000_0000;
  endfunction : peek
  task automatic poke(input logic [31:0] a, input logic [31:0] d);
    mem[a[31:2]] = d;
  endtask : poke
  // ack at once or after a stretch; read data churns when not acked
  always @(posedge clk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (!resetn_i) begin
      wait_cnt <= 3'h0;
      mem_rdata_o <= 32'h0000_0000;
    end else if (mem_req_i && !mem_ack_o) begin
      wait_cnt <= wait_cnt + 3'h1;
      if (!slow_i || wait_cnt == 3'h3) begin
        wait_cnt <= 3'h0;
        mem_ack_o <= 1'b1;
        word = peek(mem_cmd_i.addr);
        mem_rdata_o <= word;
        for (int i = 0; i < 4; i++) begin
          if (mem_cmd_i.we && mem_cmd_i.be[i]) word[8*i+:8] = mem_cmd_i.wdata[8*i+:8];
        end
        if (mem_cmd_i.we) poke(mem_cmd_i.addr, word);
      end
    end
  end
endmodule : rxd_mem_model
`default_nettype wire

// [tb.sv]
// self-checking bench for the receive descriptor dma
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import rxd_pkg::*;
  logic clk_i, resetn_i, start_i, halt_i, early_en, avail, take, in_valid, in_ready;
  logic req, ack, busy, done, slow;
  logic [31:0] list_ptr, rdata, status, cur_ptr;
  logic [12:0] thresh;
  logic [15:0] size_lim;
  rxd_frame_info_t info;
  rxd_beat_t beat;
  rxd_mem_cmd_t cmd;
  int mismatches, n_checks;
  rxd_dma dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .start_i(start_i), .list_ptr_i(list_ptr),
    .halt_i(halt_i), .early_receive_enable_i(early_en), .early_receive_threshold_i(thresh),
    .frame_size_limit_i(size_lim), .frame_avail_i(avail), .frame_info_i(info),
    .frame_take_o(take), .in_valid_i(in_valid), .in_beat_i(beat), .in_ready_o(in_ready),
    .mem_req_o(req), .mem_cmd_o(cmd), .mem_ack_i(ack), .mem_rdata_i(rdata),
    .status_o(status), .current_descriptor_pointer_o(cur_ptr), .busy_o(busy),
    .frame_done_o(done));
  rxd_mem_model mem_u (.clk_i(clk_i), .resetn_i(resetn_i), .slow_i(slow), .mem_req_i(req),
    .mem_cmd_i(cmd), .mem_ack_o(ack), .mem_rdata_o(rdata));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // descriptor with up to two fragments
  task automatic desc(input logic [31:0] a, nxt, st, f0a, f0l, f1a, f1l);
    mem_u.poke(a, nxt);
    mem_u.poke(a + 32'h4, st);
    mem_u.poke(a + 32'h8, f0a);
    mem_u.poke(a + 32'hC, f0l);
    mem_u.poke(a + 32'h10, f1a);
    mem_u.poke(a + 32'h14, f1l);
  endtask : desc
  task automatic go(input logic [31:0] p);
    list_ptr <= p;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
  endtask : go
  // frame info then bytes A0, A1, ...
  task automatic frame(input int n, input logic [2:0] fl);
    int w;
    w = 0;
    avail <= 1'b1;
    info <= '{len: 16'(n), checksum_bad: fl[2], trailing_bits: fl[1], fifo_overrun: fl[0]};
    do begin
      @(posedge clk_i);
      w++;
    end while (!take && w < 500);
    avail <= 1'b0;
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      beat <= '{data: 8'(8'hA0 + i), last: (i == n - 1)};
      do @(posedge clk_i); while (!in_ready);
    end
    in_valid <= 1'b0;
  endtask : frame
  task automatic wait_done();
    int w;
    w = 0;
    do begin
      @(posedge clk_i);
      w++;
    end while (!done && w < 3000);
    chk(32'(w < 3000), 32'h1);
  endtask : wait_done
  task automatic chk_bytes(input logic [31:0] a, input int first, input int n);
    logic [31:0] b;
    for (int i = 0; i < n; i++) begin
      b = a + 32'(i);
      chk(32'(8'(mem_u.peek(b) >> {b[1:0], 3'b000})), 32'h0A0 + 32'(first + i));
    end
  endtask : chk_bytes
  task automatic chk_stat(input logic [31:0] d, input logic [31:0] exp);
    chk(mem_u.peek(d + 32'h4) & 32'hEFFF_FFFF, exp);
  endtask : chk_stat
  // two odd-aligned fragments, slow memory, bad checksum with trailing bits, short frame
  task automatic t_frag();
    slow <= 1'b1;
    early_en <= 1'b1;
    desc(32'h100, 32'h0, 32'h0, 32'h2001, 32'h3, 32'h3003, 32'h8000_0005);
    go(32'h100);
    frame(8, 3'b110);
    wait_done();
    chk_stat(32'h100, 32'h008E_C008);
    chk_bytes(32'h2001, 0, 3);
    chk_bytes(32'h3003, 3, 5);
    repeat (5) @(posedge clk_i);
    chk(32'(busy), 32'h0);
    $display("test frag done");
  endtask : t_frag
  // overflow, halt, then implied buffer with oversize and overrun
  task automatic t_chain();
    slow <= 1'b0;
    halt_i <= 1'b1;
    desc(32'h200, 32'h300, 32'h0, 32'h4000, 32'h8000_0004, 32'h0, 32'h0);
    desc(32'h300, 32'h0, 32'h1000_0000, 32'h0, 32'h0, 32'h0, 32'h0);
    go(32'h200);
    frame(62, 3'b010);
    wait_done();
    chk_stat(32'h200, 32'h0180_8004);
    chk_bytes(32'h4000, 0, 4);
    repeat (20) @(posedge clk_i);
    chk({30'h0, busy, req}, 32'h2);
    chk(status, 32'h0180_8004);
    chk(cur_ptr, 32'h0000_0200);
    halt_i <= 1'b0;
    size_lim <= 16'h0005;
    frame(5, 3'b001);
    wait_done();
    chk_stat(32'h300, 32'h0013_C005);
    chk_bytes(32'h308, 0, 5);
    size_lim <= 16'h0600;
    $display("test chain done");
  endtask : t_chain
  // short frame dropped without early receive, passed with it
  task automatic t_runt();
    early_en <= 1'b0;
    desc(32'h400, 32'h0, 32'h0, 32'h5000, 32'h8000_0040, 32'h0, 32'h0);
    go(32'h400);
    frame(10, 3'b000);
    repeat (40) @(posedge clk_i);
    chk(mem_u.peek(32'h404), 32'h0);
    early_en <= 1'b1;
    thresh <= 13'h0005;
    frame(10, 3'b000);
    wait_done();
    chk_stat(32'h400, 32'h0002_C00A);
    chk_bytes(32'h5000, 0, 10);
    $display("test runt done");
  endtask : t_runt
  // counts and verdict
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end
  initial begin
    {resetn_i, start_i, halt_i, early_en, avail, in_valid, slow} = '0;
    list_ptr = '0;
    thresh = '0;
    size_lim = 16'h0600;
    info = '0;
    beat = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(posedge clk_i);
    t_frag();
    t_chain();
    t_runt();
    stop_test();
  end
endmodule : tb
`default_nettype wire
